// ### fsp_pkg.sv
`default_nettype none
// ==================================================
// self-program sequencer constants
package fsp_pkg;
    // ==================================================
    // clock and programming time
    localparam int CLK_MHZ      = 125;  // clk_sys rate
    localparam int PROG_MIN_US  = 3700; // least flash write time, us
    localparam int PROG_MAX_US  = 4500; // longest flash write time, us
    // least write time used; whole us times MHz is exact
    localparam int PROG_CYCLES  = PROG_MIN_US * CLK_MHZ;
    localparam logic [2:0] SIG_WIN = 3'h3; // cpu cycles to issue the load
    localparam logic [2:0] SPM_WIN = 3'h4; // cpu cycles to issue the store
    localparam logic [2:0] WIN_ONE = 3'h1; // last cycle of a window

    // ==================================================
    // flash geometry and pointer fields
    localparam int PC_W      = 12; // program counter width
    localparam int PAGE_W    = 7;  // page select width
    localparam int WORD_W    = 5;  // word in page width
    localparam int Z_BYTE    = 0;  // byte select bit
    localparam int Z_WRD_LSB = 1;  // word field low bit
    localparam int Z_PG_LSB  = 6;  // page field low bit
    localparam int Z_PC_MSB  = 12; // highest decoded pointer bit
    localparam logic [PC_W-1:0] HALT_START = 12'hc00; // halting section
    localparam logic [PC_W-1:0] BOOT_ST_11 = 12'hf80; // 128 words
    localparam logic [PC_W-1:0] BOOT_ST_10 = 12'hf00; // 256 words
    localparam logic [PC_W-1:0] BOOT_ST_01 = 12'he00; // 512 words
    localparam logic [PC_W-1:0] BOOT_ST_00 = 12'hc00; // 1024 words

    // ==================================================
    // register port
    localparam logic [1:0] REG_CTRL = 2'h0; // control and status
    localparam logic [1:0] REG_STAT = 2'h1; // engine and boot status
    localparam int B_EN    = 0; // self_program_enable
    localparam int B_ERASE = 1; // page_erase_cmd
    localparam int B_WRITE = 2; // page_write_cmd
    localparam int B_REEN  = 4; // concurrent_section_reenable
    localparam int B_SIGNATURE_READ_SELECT = 5; // signature_read_select
    localparam int B_BUSY  = 6; // concurrent_section_busy
    localparam int S_RUN   = 0; // engine running
    localparam int S_EE    = 1; // eeprom write seen active
    localparam int S_BOOT  = 2; // boot size, two bits
    localparam int S_HALT  = 4; // cpu halted
    localparam logic [7:0] RD_IDLE = 8'h00; // unmapped and idle read
    // low seven bits of a control write; bit 7 is don't care
    localparam logic [6:0] CMD_LOAD  = 7'h01;
    localparam logic [6:0] CMD_ERASE = 7'h03;
    localparam logic [6:0] CMD_WRITE = 7'h05;
    localparam logic [6:0] CMD_REEN  = 7'h11;
    localparam logic [6:0] CMD_SIG   = 7'h21;

    // ==================================================
    // signature row byte addresses
    localparam logic [5:0] SIG_MFR    = 6'h00;
    localparam logic [5:0] SIG_CAL    = 6'h01;
    localparam logic [5:0] SIG_SIZE   = 6'h02;
    localparam logic [5:0] SIG_DEV    = 6'h04;
    localparam logic [5:0] SIG_TSOFF  = 6'h05;
    localparam logic [5:0] SIG_TEMP_SENSOR_GAIN_BYTE = 6'h07;
    localparam logic [5:0] SIG_LOT0   = 6'h0e;
    localparam logic [5:0] SIG_LOT5   = 6'h13;
    localparam logic [5:0] SIG_AMB_LO = 6'h3c;
    localparam logic [5:0] SIG_AMB_HI = 6'h3d;
    localparam logic [5:0] SIG_HOT_LO = 6'h3e;
    localparam logic [5:0] SIG_HOT_HI = 6'h3f;
    localparam logic [7:0] SIG_EMPTY  = 8'hff; // reserved and unlisted

    // ==================================================
    // window state
    typedef enum logic [1:0] {
        FSP_WIN_IDLE = 2'b00,
        FSP_WIN_SIG  = 2'b01,
        FSP_WIN_SPM  = 2'b10
    } fsp_win_t;
endpackage
`default_nettype wire

// ### fsp_self_program.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - signature byte returned on load in window
// - select and enable clear after read/timeout
// - cleared bits give ordinary flash loads
// - calibration, sensor offset, gain at fixed addresses
// - three identity bytes at 0x00/0x02/0x04
// - lot characters at 0x0E..0x13
// - two reference words, low byte first
// - running flash write survives system reset
// - flash write lasts 3.7 ms, the least write time
// - two strap bits pick boot size
// - concurrent 96 pages, halting 32 pages
// - program counter is twelve bits
// - 32 words a page, word from Z5:Z1
// - page select from Z12:Z6
// - Z15:Z13 ignored
// - Z0 selects byte on loads
// - concurrent section fetches blocked while programming
// - busy blocks concurrent section fetches until re-enable store
// - control patterns pick erase, write, load
// - busy stays set while section busy
module fsp_self_program #(
    parameter logic [7:0]  MFR_CODE    = 8'h5a,     // arbitrary value
    parameter logic [7:0]  SIZE_CODE   = 8'h3c,     // arbitrary value
    parameter logic [7:0]  DEV_CODE    = 8'h7e,     // arbitrary value
    parameter logic [7:0]  RC_CAL      = 8'h80,     // factory trim
    parameter logic [7:0]  TS_OFFSET   = 8'h00,     // sensor offset
    parameter logic [7:0]  TS_GAIN     = 8'h80,     // sensor gain
    parameter logic [47:0] LOT_ID      = 48'h0,     // lot chars, 0x0e in low byte
    parameter logic [15:0] VREF_AMB    = 16'h0a00,  // mV at ambient
    parameter logic [15:0] VREF_HOT    = 16'h0a00,  // mV at hot test
    parameter int          PROG_CYCLES = fsp_pkg::PROG_CYCLES // write length
) (
    input  wire logic                     clk_sys,             // system clock
    input  wire logic                     rst,                 // system reset
    input  wire logic                     por,                 // supply reset
    input  wire logic [1:0]               reg_addr,            // register index
    input  wire logic [7:0]               reg_wdata,           // write data
    input  wire logic                     reg_wr,              // write strobe
    input  wire logic                     reg_rd,              // read strobe
    output logic [7:0]                    reg_rdata,           // read data
    input  wire logic                     lpm_req,             // program load
    input  wire logic                     spm_req,             // program store
    input  wire logic [15:0]              z_ptr,               // z pointer
    input  wire logic [15:0]              spm_data,            // r1:r0 word
    input  wire logic [15:0]              flash_word,          // array read word
    output logic [fsp_pkg::PC_W-1:0]      flash_addr,          // array read addr
    output logic [7:0]                    lpm_data,            // load result
    output logic                          lpm_valid,           // load result valid
    output logic                          buf_we,              // page buffer write
    output logic [fsp_pkg::WORD_W-1:0]    buf_word,            // buffer word
    output logic [15:0]                   buf_data,            // buffer data
    output logic                          buf_clr,             // buffer erase
    output logic                          flash_erase_go,      // start erase
    output logic                          flash_write_go,      // start write
    output logic [fsp_pkg::PAGE_W-1:0]    flash_page,          // target page
    output logic                          cpu_halt,            // halt fetches
    input  wire logic [fsp_pkg::PC_W-1:0] fetch_addr,          // cpu fetch addr
    output logic                          fetch_blocked,       // fetch refused
    input  wire logic                     eeprom_write_active, // eeprom pin
    input  wire logic                     boot_size_sel_high,  // boot strap
    input  wire logic                     boot_size_sel_low,   // boot strap
    output logic [fsp_pkg::PC_W-1:0]      boot_start           // boot reset addr
);
    import fsp_pkg::*;

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PROG_CYCLES);
    localparam logic [6:0] CONC_PAGES = 7'd96; // pages below halting section

    // ==================================================
    // state
    typedef struct packed {
        fsp_win_t          win;      // command window
        logic [2:0]        win_cnt;  // cycles left in window
        logic              en;       // self_program_enable
        logic              signature_read_select;    // signature_read_select
        logic              erase;    // page_erase_cmd
        logic              write;    // page_write_cmd
        logic              reen;     // concurrent_section_reenable
        logic              busy;     // concurrent_section_busy
        logic [2:0]        ee_sync;  // eeprom pin synchroniser
        logic              ee_act;   // eeprom write, filtered
        logic              boot_cap; // straps taken
        logic [1:0]        boot_sz;  // boot size code
        logic [PC_W-1:0]   boot_st;  // boot start address
        logic [7:0]        rdata;    // read data
        logic              p1;       // load in flight
        logic              p1_sig;   // load targets signature row
        logic [5:0]        p1_sa;    // signature address
        logic              p1_b;     // high byte select
        logic [PC_W-1:0]   faddr;    // flash read address
        logic [7:0]        ldata;    // load result
        logic              lvalid;   // load result valid
        logic              bwe;      // buffer write
        logic [WORD_W-1:0] bword;    // buffer word
        logic [15:0]       bdata;    // buffer data
        logic              bclr;     // buffer erase
        logic              fblk;     // fetch refused
    } fsp_main_t;

    // kept apart because only the supply reset may stop a write
    typedef struct packed {
        logic              run;   // array busy
        logic              halt;  // cpu halted
        logic              go_er; // erase start pulse
        logic              go_wr; // write start pulse
        logic [PAGE_W-1:0] page;  // target page
        logic [CNT_W-1:0]  cnt;   // cycles left
    } fsp_eng_t;

    localparam fsp_main_t MAIN_RST = '0;
    localparam fsp_eng_t  ENG_RST  = '0;

    fsp_main_t s, next_s; // main state
    fsp_eng_t  e, next_e; // engine state
    logic      eng_done;  // last engine cycle
    logic      ctl_ok;    // control write allowed
    logic      sig_ld;    // signature load taken
    logic      spm_ok;    // store taken

    // ==================================================
    // signature row lookup
    function automatic logic [7:0] sig_byte(input logic [5:0] a);
        logic [5:0] li;
        li = a - SIG_LOT0;
        case (a)
            SIG_MFR:    sig_byte = MFR_CODE;
            SIG_SIZE:   sig_byte = SIZE_CODE;
            SIG_DEV:    sig_byte = DEV_CODE;
            SIG_CAL:    sig_byte = RC_CAL;
            SIG_TSOFF:  sig_byte = TS_OFFSET;
            SIG_TEMP_SENSOR_GAIN_BYTE: sig_byte = TS_GAIN;
            SIG_AMB_LO: sig_byte = VREF_AMB[7:0];
            SIG_AMB_HI: sig_byte = VREF_AMB[15:8];
            SIG_HOT_LO: sig_byte = VREF_HOT[7:0];
            SIG_HOT_HI: sig_byte = VREF_HOT[15:8];
            default: begin
                // lot chars in address order, leftmost at 0x0e
                if (a >= SIG_LOT0 && a <= SIG_LOT5) begin
                    sig_byte = LOT_ID[{li[2:0], 3'h0} +: 8];
                end else begin
                    sig_byte = SIG_EMPTY; // reserved bytes
                end
            end
        endcase
    endfunction

    // ==================================================
    // next state
    always_comb begin
        next_s = s;
        next_e = e;
        // pulses last one cycle
        next_s.bwe    = 1'b0;
        next_s.bclr   = 1'b0;
        next_s.lvalid = 1'b0;
        next_s.p1     = 1'b0;
        next_s.rdata  = RD_IDLE;
        next_e.go_er  = 1'b0;
        next_e.go_wr  = 1'b0;

        // eeprom pin: change counts once stages two and three agree
        next_s.ee_sync = {s.ee_sync[1:0], eeprom_write_active};
        if (s.ee_sync[2] == s.ee_sync[1]) begin
            next_s.ee_act = s.ee_sync[2];
        end

        // straps caught once after reset release, then held
        if (!s.boot_cap) begin
            next_s.boot_cap = 1'b1;
            next_s.boot_sz  = {boot_size_sel_high, boot_size_sel_low};
            case ({boot_size_sel_high, boot_size_sel_low})
                2'b11:   next_s.boot_st = BOOT_ST_11;
                2'b10:   next_s.boot_st = BOOT_ST_10;
                2'b01:   next_s.boot_st = BOOT_ST_01;
                default: next_s.boot_st = BOOT_ST_00;
            endcase
        end

        // engine countdown; timed from the trimmed clock
        eng_done = e.run && (e.cnt == CNT_ONE);
        if (e.run) begin
            next_e.cnt = e.cnt - CNT_ONE;
            if (eng_done) begin
                next_e.run  = 1'b0;
                next_e.halt = 1'b0;
            end
        end
        if (eng_done) begin
            // enable drops; busy stays until re-enabled
            next_s.en    = 1'b0;
            next_s.erase = 1'b0;
            next_s.write = 1'b0;
            next_s.bclr  = s.write; // buffer empties after a page write
        end

        // window expiry when nothing was issued
        sig_ld = lpm_req && (s.win == FSP_WIN_SIG);
        spm_ok = spm_req && (s.win == FSP_WIN_SPM);
        if (s.win != FSP_WIN_IDLE && !sig_ld && !spm_ok) begin
            next_s.win_cnt = s.win_cnt - WIN_ONE;
            if (s.win_cnt == WIN_ONE) begin
                next_s.win   = FSP_WIN_IDLE;
                next_s.en    = 1'b0;
                next_s.signature_read_select = 1'b0;
                next_s.erase = 1'b0;
                next_s.write = 1'b0;
                next_s.reen  = 1'b0;
            end
        end

        // program loads: flash word fetched, byte picked one cycle later
        if (lpm_req) begin
            next_s.p1     = 1'b1;
            next_s.p1_sig = sig_ld;
            next_s.p1_sa  = z_ptr[5:0];
            next_s.p1_b   = z_ptr[Z_BYTE];
            next_s.faddr  = z_ptr[Z_PC_MSB:Z_WRD_LSB];
            if (sig_ld) begin
                next_s.win   = FSP_WIN_IDLE;
                next_s.en    = 1'b0;
                next_s.signature_read_select = 1'b0;
            end
        end
        if (s.p1) begin
            next_s.lvalid = 1'b1;
            if (s.p1_sig) begin
                next_s.ldata = sig_byte(s.p1_sa);
            end else if (s.p1_b) begin
                next_s.ldata = flash_word[15:8];
            end else begin
                next_s.ldata = flash_word[7:0];
            end
        end

        // stores inside the window
        if (spm_ok) begin
            next_s.win = FSP_WIN_IDLE;
            if (s.erase || s.write) begin
                // concurrent section fetches refused until re-enabled
                next_e.run  = 1'b1;
                next_e.cnt  = CNT_LOAD;
                next_e.page = z_ptr[Z_PC_MSB:Z_PG_LSB];
                next_e.go_er = s.erase;
                next_e.go_wr = s.write; // word field assumed zero by software
                next_e.halt = (z_ptr[Z_PC_MSB:Z_PG_LSB] >= CONC_PAGES);
                next_s.busy = 1'b1;
            end else if (s.reen) begin
                next_s.en   = 1'b0;
                next_s.reen = 1'b0;
                next_s.bclr = 1'b1;
                if (!e.run) begin
                    next_s.busy = 1'b0;
                end
            end else begin
                next_s.en    = 1'b0;
                next_s.bwe   = 1'b1;
                next_s.bword = z_ptr[Z_PG_LSB-1:Z_WRD_LSB];
                next_s.bdata = spm_data;
            end
        end

        // control writes refused while a command is pending or eeprom busy
        ctl_ok = reg_wr && (reg_addr == REG_CTRL) && !s.en && !s.ee_act
                 && !e.run;
        if (ctl_ok) begin
            next_s.win_cnt = SPM_WIN;
            case (reg_wdata[6:0])
                CMD_SIG: begin
                    next_s.win     = FSP_WIN_SIG;
                    next_s.win_cnt = SIG_WIN;
                    next_s.en      = 1'b1;
                    next_s.signature_read_select   = 1'b1;
                end
                CMD_LOAD: begin
                    next_s.win = FSP_WIN_SPM;
                    next_s.en  = 1'b1;
                end
                CMD_ERASE: begin
                    next_s.win   = FSP_WIN_SPM;
                    next_s.en    = 1'b1;
                    next_s.erase = 1'b1;
                end
                CMD_WRITE: begin
                    next_s.win   = FSP_WIN_SPM;
                    next_s.en    = 1'b1;
                    next_s.write = 1'b1;
                end
                CMD_REEN: begin
                    next_s.win  = FSP_WIN_SPM;
                    next_s.en   = 1'b1;
                    next_s.reen = 1'b1;
                end
                default: begin
                    next_s.win_cnt = s.win_cnt; // unknown pattern ignored
                end
            endcase
        end

        // register reads, answered next cycle
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: begin
                    next_s.rdata[B_EN]    = s.en;
                    next_s.rdata[B_ERASE] = s.erase;
                    next_s.rdata[B_WRITE] = s.write;
                    next_s.rdata[B_REEN]  = s.reen;
                    next_s.rdata[B_SIGNATURE_READ_SELECT] = s.signature_read_select;
                    next_s.rdata[B_BUSY]  = s.busy;
                end
                REG_STAT: begin
                    next_s.rdata[S_RUN]       = e.run;
                    next_s.rdata[S_EE]        = s.ee_act;
                    next_s.rdata[S_BOOT +: 2] = s.boot_sz;
                    next_s.rdata[S_HALT]      = e.halt;
                end
                default: begin
                    next_s.rdata = RD_IDLE;
                end
            endcase
        end

        // concurrent section fetches refused while programming or busy
        next_s.fblk = (s.busy || e.run) && (fetch_addr < HALT_START);
    end

    // ==================================================
    // registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= MAIN_RST;
        end else begin
            s <= next_s;
        end
    end

    // engine ignores the system reset so a write finishes unless the supply reset comes
    always_ff @(posedge clk_sys or posedge por) begin
        if (por) begin
            e <= ENG_RST;
        end else begin
            e <= next_e;
        end
    end

    // ==================================================
    // outputs
    assign reg_rdata      = s.rdata;
    assign flash_addr     = s.faddr;
    assign lpm_data       = s.ldata;
    assign lpm_valid      = s.lvalid;
    assign buf_we         = s.bwe;
    assign buf_word       = s.bword;
    assign buf_data       = s.bdata;
    assign buf_clr        = s.bclr;
    assign flash_erase_go = e.go_er;
    assign flash_write_go = e.go_wr;
    assign flash_page     = e.page;
    assign cpu_halt       = e.halt;
    assign fetch_blocked  = s.fblk;
    assign boot_start     = s.boot_st;

    // ==================================================
    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst || por);

    chk_sig_value: assert property (
        (lpm_req && s.win == FSP_WIN_SIG && z_ptr[5:0] == SIG_CAL)
        |-> ##2 (lpm_valid && lpm_data == RC_CAL))
        else $error("signature byte not returned");
    chk_sig_expire: assert property (
        (s.win == FSP_WIN_SIG && s.win_cnt == WIN_ONE && !lpm_req)
        |=> (!s.en && !s.signature_read_select))
        else $error("signature window did not expire");
    chk_plain_load: assert property (
        (lpm_req && s.win == FSP_WIN_IDLE && !z_ptr[Z_BYTE])
        |=> ##1 (lpm_valid && lpm_data == $past(flash_word[7:0])))
        else $error("plain load returned wrong byte");
    chk_prog_hold: assert property (
        $rose(e.run) |-> e.run [*8])
        else $error("flash write ended early");
    chk_page_field: assert property (
        (spm_ok && s.erase)
        |=> (flash_erase_go && flash_page == $past(z_ptr[12:6])))
        else $error("erase page wrong");
    chk_word_field: assert property (
        (spm_ok && !s.erase && !s.write && !s.reen)
        |=> (buf_we && buf_word == $past(z_ptr[5:1])))
        else $error("buffer word wrong");
    chk_fetch_block: assert property (
        (e.run && fetch_addr < HALT_START) |=> fetch_blocked)
        else $error("concurrent fetch not blocked");
    chk_reenable: assert property (
        (spm_ok && s.reen && !e.run) |=> !s.busy)
        else $error("busy not cleared by re-enable");
    chk_boot_small: assert property (
        (s.boot_cap && s.boot_sz == 2'b11) |-> boot_start == BOOT_ST_11)
        else $error("boot start wrong");

    cov_sig_read: cover property (sig_ld ##2 lpm_valid);
    cov_erase:    cover property (flash_erase_go ##1 e.run);
    cov_timeout:  cover property (s.win == FSP_WIN_SPM ##1 s.win == FSP_WIN_IDLE);
    cov_reenable: cover property (spm_ok && s.reen);
endmodule
`default_nettype wire

// ### fsp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// flash array stand-in
module fsp_flash_model (
    input  wire logic [11:0] flash_addr, // read address
    output logic      [15:0] flash_word  // read word
);
    // unlike bytes, so a swapped byte select shows
    assign flash_word = {4'ha, flash_addr} ^ 16'h0f00;
endmodule
`default_nettype wire

// ### flash_self_program_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_map_tb;
    import fsp_pkg::*;
    logic clk_sys = 0, rst = 1, por = 1, reg_wr = 0, reg_rd = 0;
    logic lpm_req = 0, spm_req = 0, eeprom_write_active = 0;
    logic boot_size_sel_high = 1, boot_size_sel_low = 1;
    logic [1:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, lpm_data;
    logic [15:0] z_ptr = 0, spm_data = 0, flash_word, buf_data;
    logic [11:0] flash_addr, fetch_addr = 0, boot_start;
    logic [6:0] flash_page;
    logic [4:0] buf_word;
    logic lpm_valid, buf_we, buf_clr, flash_erase_go, flash_write_go;
    logic cpu_halt, fetch_blocked;
    int mismatches = 0, total_checks = 0;
    fsp_self_program #(.MFR_CODE(8'h5a), .RC_CAL(8'h3b),
        .LOT_ID(48'h363534333231), .VREF_HOT(16'h0b2c),
        .PROG_CYCLES(20)) u_fsp_self_program (.*);
    fsp_flash_model u_fsp_flash_model (.*);
    initial forever #4 clk_sys = ~clk_sys;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1;
        reg_addr <= REG_CTRL;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] m, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1;
        reg_addr <= REG_CTRL;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 chk({4'h0, reg_rdata & m}, {4'h0, exp});
    endtask
    task automatic lpm(input logic [15:0] z, input logic [7:0] exp);
        @(posedge clk_sys);
        lpm_req <= 1;
        z_ptr <= z;
        @(posedge clk_sys);
        lpm_req <= 0;
        @(posedge clk_sys);
        #1 chk({3'h0, lpm_valid, lpm_data}, {4'h1, exp});
    endtask
    task automatic spm(input logic [15:0] z);
        @(posedge clk_sys);
        spm_req <= 1;
        z_ptr <= z;
        @(posedge clk_sys);
        spm_req <= 0;
    endtask
    task automatic sig(input logic [5:0] a, input logic [7:0] exp);
        wr(8'h21);
        lpm({10'h0, a}, exp);
    endtask
    // ==================================================
    // watchdog: the whole run needs well under 600 cycles
    initial begin
        repeat (2000) @(posedge clk_sys);
        mismatches++;
        end_of_test;
    end
    // ==================================================
    // main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        por <= 0;
        sig(6'h00, 8'h5a);
        sig(6'h01, 8'h3b);
        sig(6'h03, 8'hff);
        sig(6'h0f, 8'h32);
        sig(6'h3e, 8'h2c);
        sig(6'h3f, 8'h0b);
        chk(boot_start, 12'hf80);
        // window left to lapse: plain flash byte comes back
        wr(8'h21);
        repeat (4) @(posedge clk_sys);
        lpm(16'he123, 8'haf);
        lpm(16'h0122, 8'h91);
        wr(8'h03);
        spm(16'h1fc0);
        #1 chk({4'h0, flash_erase_go, flash_page}, 12'h0ff);
        rd(8'h41, 8'h41);
        chk({11'h0, cpu_halt}, 12'h001);
        repeat (25) @(posedge clk_sys);
        rd(8'h41, 8'h40);
        wr(8'h11);
        spm(16'h0000);
        repeat (2) @(posedge clk_sys);
        rd(8'h40, 8'h00);
        // page load into the buffer, word from z5:z1
        wr(8'h01);
        spm_data <= 16'hbeef;
        spm(16'h003e);
        #1 chk({buf_we, buf_word, 6'h0}, {1'b1, 5'h1f, 6'h0});
        chk(buf_data[15:4], 12'hbee);
        // page write to a concurrent page, word field held at zero
        wr(8'h05);
        fetch_addr <= 12'h100;
        spm(16'h0040);
        #1 chk({flash_write_go, cpu_halt, 3'h0, flash_page}, 12'h801);
        @(posedge clk_sys);
        #1 chk({11'h0, fetch_blocked}, 12'h001);
        // system reset mid-write with new straps
        @(posedge clk_sys);
        boot_size_sel_high <= 0;
        boot_size_sel_low <= 0;
        rst <= 1;
        @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        @(posedge clk_sys);
        #1 chk(boot_start, 12'hc00);
        @(posedge clk_sys);
        reg_rd <= 1;
        reg_addr <= REG_STAT;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 chk({4'h0, reg_rdata}, 12'h001);
        repeat (25) @(posedge clk_sys);
        #1 chk({11'h0, fetch_blocked}, 12'h000);
        // eeprom busy refuses the control write
        eeprom_write_active <= 1;
        repeat (5) @(posedge clk_sys);
        wr(8'h01);
        rd(8'h01, 8'h00);
        eeprom_write_active <= 0;
        repeat (5) @(posedge clk_sys);
        // store after the window has lapsed is ignored
        wr(8'h01);
        repeat (5) @(posedge clk_sys);
        spm(16'h0002);
        #1 chk({11'h0, buf_we}, 12'h000);
        end_of_test;
    end
endmodule
`default_nettype wire
